// >>> include/ddrmr_params.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Included by the mode register block
// Notes: Functional notes follow
`ifndef DDRMR_PARAMS_SVH
`define DDRMR_PARAMS_SVH

`define DDRMR_ADR_CTRL 8'h00
`define DDRMR_ADR_STATUS 8'h04
`define DDRMR_ADR_MMR 8'h08
`define DDRMR_ADR_EXT1 8'h0c
`define DDRMR_ADR_EXT2 8'h10
`define DDRMR_ADR_EXT3 8'h14

`define DDRMR_CTRL_RST 1'b1
`define DDRMR_REG_RST 14'h0000

`define DDRMR_BA_MMR 3'h0
`define DDRMR_BA_EXT1 3'h1
`define DDRMR_BA_EXT2 3'h2
`define DDRMR_BA_EXT3 3'h3

`define DDRMR_MMR_BL 0
`define DDRMR_MMR_BT 3
`define DDRMR_MMR_CL 4
`define DDRMR_MMR_TM 7
`define DDRMR_MMR_DLLRST 8
`define DDRMR_MMR_WR 9
`define DDRMR_EXT1_DLLDIS 0
`define DDRMR_EXT1_ODC 7

`define DDRMR_DLL_SYNC_CLKS 200

`endif

// >>> include/ddrmr_pkg.sv
// Purpose: Types of the DDR2 mode register block
// Assumes: Nothing
// Notes: Pin group and decoded mode travel as structs
package ddrmr_pkg;

	typedef struct packed {
		logic cke;
		logic odt;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [13:0] addr;
	} ddrmr_pins_t;

	typedef struct packed {
		logic [2:0] burst_len;
		logic burst_seq;
		logic [2:0] cas_lat;
		logic test_mode;
		logic dll_reset;
		logic [2:0] write_rec;
		logic dll_disable;
		logic [2:0] odc_op;
	} ddrmr_mode_t;

	typedef enum logic [1:0] {
		DLL_OFF,
		DLL_LOCKING,
		DLL_READY
	} ddrmr_dll_t;

endpackage

// >>> rtl/ddrmr_sync.sv
// Purpose: Two-stage synchroniser for the pin group
// Assumes: Inputs asynchronous to clk_sys
// Notes: Only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module ddrmr_sync #(
	parameter int W = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/ddrmr_top.sv
// Purpose: DDR2 mode and extended mode registers with DLL status
// Assumes: Pins sampled by clk_sys, link clock far slower
// Notes: Registers readable over classic Wishbone
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "ddrmr_params.svh"
module ddrmr_top #(
	parameter int DLL_CLKS = `DDRMR_DLL_SYNC_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ddr_ck_i,
	input wire ddrmr_pkg::ddrmr_pins_t ddr_pins_i,
	output ddrmr_pkg::ddrmr_mode_t mode_o,
	output logic clk_active_o,
	output logic dll_ready_o
);
	import ddrmr_pkg::*;

	logic [23:0] sync_q;
	ddrmr_pins_t pins_s;
	logic ck_s;
	logic ck_d_q;
	logic link_edge;
	logic ck_tick;
	logic cmd_live;
	logic set_cmd;
	logic clk_en_q;
	logic listen_q;
	logic dll_en_q;
	logic [13:0] mmr_q;
	logic [13:0] ext1_q;
	logic [13:0] ext2_q;
	logic [13:0] ext3_q;
	ddrmr_mode_t mode_q;
	ddrmr_dll_t dll_st_q;
	logic [7:0] dll_cnt_q;
	logic dll_ready_q;
	logic wb_hit;
	logic wb_done;
	logic wb_ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;

	ddrmr_sync #(.W(24)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d_i({ddr_ck_i, ddr_pins_i}),
		.q_o(sync_q)
	);

	assign ck_s = sync_q[23];
	assign pins_s = sync_q[22:0];

	// Rising edge of the memory clock as seen by clk_sys
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ck_d_q <= 1'b0;
		end else begin
			ck_d_q <= ck_s;
		end
	end
	assign link_edge = ck_s & ~ck_d_q;

	// Clock enable registered at each memory clock edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clk_en_q <= 1'b0;
		end else if (link_edge) begin
			clk_en_q <= pins_s.cke;
		end
	end

	assign ck_tick = link_edge & pins_s.cke;
	assign cmd_live = ck_tick & listen_q;
	assign set_cmd = cmd_live & ~pins_s.cs_n & ~pins_s.ras_n
		& ~pins_s.cas_n & ~pins_s.we_n;

	// Register writes; bank address picks the target
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mmr_q <= `DDRMR_REG_RST;
			ext1_q <= `DDRMR_REG_RST;
			ext2_q <= `DDRMR_REG_RST;
			ext3_q <= `DDRMR_REG_RST;
		end else if (set_cmd) begin
			if (pins_s.ba == `DDRMR_BA_MMR) begin
				mmr_q <= pins_s.addr;
			end else if (pins_s.ba == `DDRMR_BA_EXT1) begin
				ext1_q <= pins_s.addr;
			end else if (pins_s.ba == `DDRMR_BA_EXT2) begin
				ext2_q <= pins_s.addr;
			end else if (pins_s.ba == `DDRMR_BA_EXT3) begin
				ext3_q <= pins_s.addr;
			end
		end
	end

	// Field decode of the stored main and extended 1 registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_q <= '0;
		end else begin
			mode_q.burst_len <= mmr_q[`DDRMR_MMR_BL +: 3];
			mode_q.burst_seq <= mmr_q[`DDRMR_MMR_BT];
			mode_q.cas_lat <= mmr_q[`DDRMR_MMR_CL +: 3];
			mode_q.test_mode <= mmr_q[`DDRMR_MMR_TM];
			mode_q.dll_reset <= mmr_q[`DDRMR_MMR_DLLRST];
			mode_q.write_rec <= mmr_q[`DDRMR_MMR_WR +: 3];
			mode_q.dll_disable <= ext1_q[`DDRMR_EXT1_DLLDIS];
			mode_q.odc_op <= ext1_q[`DDRMR_EXT1_ODC +: 3];
		end
	end

	// DLL enable loads the inverse of extended register 1 bit 0 on each write to that register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dll_en_q <= 1'b0;
		end else if (set_cmd && pins_s.ba == `DDRMR_BA_EXT1) begin
			dll_en_q <= ~pins_s.addr[`DDRMR_EXT1_DLLDIS];
		end
	end

	// DLL relock counts memory clock edges after a DLL reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dll_st_q <= DLL_OFF;
			dll_cnt_q <= 8'h00;
		end else begin
			case (dll_st_q)
				DLL_OFF: begin
					dll_cnt_q <= 8'h00;
				end
				DLL_LOCKING: begin
					if (ck_tick) begin
						dll_cnt_q <= dll_cnt_q + 8'h01;
					end
					if (ck_tick && dll_cnt_q == 8'(DLL_CLKS - 1)) begin
						dll_st_q <= DLL_READY;
					end
				end
				default: begin
					dll_cnt_q <= 8'h00;
				end
			endcase
			if (set_cmd && pins_s.ba == `DDRMR_BA_EXT1
				&& pins_s.addr[`DDRMR_EXT1_DLLDIS]) begin
				dll_st_q <= DLL_OFF;
			end else if (set_cmd && pins_s.ba == `DDRMR_BA_MMR
				&& pins_s.addr[`DDRMR_MMR_DLLRST] && dll_en_q) begin
				dll_st_q <= DLL_LOCKING;
				dll_cnt_q <= 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dll_ready_q <= 1'b0;
		end else begin
			dll_ready_q <= (dll_st_q == DLL_READY);
		end
	end

	// Wishbone slave, registered ack after one wait state per access
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_q;
	// Write lands at the edge where the master sees ack
	assign wb_done = wb_cyc_i & wb_stb_i & wb_ack_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wb_ack_q <= 1'b0;
		end else begin
			wb_ack_q <= wb_hit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			listen_q <= `DDRMR_CTRL_RST;
		end else if (wb_done && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == `DDRMR_ADR_CTRL) begin
			listen_q <= wb_dat_i[0];
		end
	end

	always_comb begin
		rdat_d = 32'h0000_0000;
		if (wb_adr_i == `DDRMR_ADR_CTRL) begin
			rdat_d[0] = listen_q;
		end else if (wb_adr_i == `DDRMR_ADR_STATUS) begin
			rdat_d[3:0] = {dll_en_q, dll_st_q == DLL_LOCKING,
				dll_ready_q, clk_en_q};
		end else if (wb_adr_i == `DDRMR_ADR_MMR) begin
			rdat_d[13:0] = mmr_q;
		end else if (wb_adr_i == `DDRMR_ADR_EXT1) begin
			rdat_d[13:0] = ext1_q;
		end else if (wb_adr_i == `DDRMR_ADR_EXT2) begin
			rdat_d[13:0] = ext2_q;
		end else if (wb_adr_i == `DDRMR_ADR_EXT3) begin
			rdat_d[13:0] = ext3_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdat_q <= 32'h0000_0000;
		end else if (wb_hit && !wb_we_i) begin
			rdat_q <= rdat_d;
		end
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = wb_ack_q;
	assign mode_o = mode_q;
	assign clk_active_o = clk_en_q;
	assign dll_ready_o = dll_ready_q;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence mmr_write;
		set_cmd && pins_s.ba == `DDRMR_BA_MMR;
	endsequence

	sequence ext1_write;
		set_cmd && pins_s.ba == `DDRMR_BA_EXT1;
	endsequence

	chk_cke_follow: assert property (
		link_edge |=> clk_en_q == $past(pins_s.cke))
		else $error("clock enable did not follow CKE");

	chk_cs_mask: assert property (
		(link_edge && pins_s.cs_n) |=> $stable(mmr_q)
		&& $stable(ext1_q) && $stable(ext2_q) && $stable(ext3_q))
		else $error("command accepted with chip select high");

	chk_mmr_load: assert property (
		mmr_write |=> mmr_q == $past(pins_s.addr))
		else $error("main register not loaded");

	chk_ext2_load: assert property (
		(set_cmd && pins_s.ba == `DDRMR_BA_EXT2)
		|=> ext2_q == $past(pins_s.addr) && $stable(mmr_q))
		else $error("extended register 2 not loaded");

	chk_other_kept: assert property (
		mmr_write |=> $stable(ext1_q) && $stable(ext3_q))
		else $error("register write disturbed other contents");

	chk_field_map: assert property (
		mmr_write ##1 1'b1 |=> mode_q.cas_lat == mmr_q[6:4]
		&& mode_q.write_rec == mmr_q[11:9]
		&& mode_q.burst_len == mmr_q[2:0])
		else $error("main register fields misplaced");

	chk_ext1_fields: assert property (
		ext1_write ##1 1'b1 |=> mode_q.odc_op == ext1_q[9:7]
		&& mode_q.dll_disable == ext1_q[0])
		else $error("extended register 1 fields misplaced");

	chk_dll_restart: assert property (
		(mmr_write and (pins_s.addr[8] && dll_en_q))
		|=> ##1 !dll_ready_q ##1 !dll_ready_q)
		else $error("DLL ready not cleared by DLL reset");
endmodule
`default_nettype wire

// >>> testbench/ddrmr_ctl_model.sv
// Purpose: Memory controller model driving clock and command pins
// Assumes: Clock period 160 ns, commands change on falling clock edge
// Notes: Released bank and address lines show the inverse of last value
`timescale 1ns/100ps
`default_nettype none
module ddrmr_ctl_model (
	output logic ck,
	output ddrmr_pkg::ddrmr_pins_t pins
);
	import ddrmr_pkg::*;
	logic run = 1'b0;
	initial begin
		pins = '1;
		pins.cke = 1'b0;
		pins.odt = 1'b0;
	end
	initial begin
		ck = 1'b0;
		forever #80 if (run) ck = ~ck;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ck);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a);
		@(negedge ck);
		{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
		pins.ba = b;
		pins.addr = a;
		@(negedge ck);
		{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'h7;
		pins.ba = ~b;
		pins.addr = ~a;
		@(negedge ck);
	endtask
	task automatic cke_set(input logic v);
		@(negedge ck);
		pins.cke = v;
	endtask
	task automatic init(input logic [13:0] mr, input logic [13:0] e1);
		run = 1'b1;
		#200000;
		@(negedge ck);
		{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'h7;
		pins.cke = 1'b1;
		tick(3);
		cmd(4'h2, 3'h0, 14'h0400);
		cmd(4'h0, 3'h2, 14'h0080);
		cmd(4'h0, 3'h3, 14'h0000);
		cmd(4'h0, 3'h1, e1 & 14'h1c7e);
		cmd(4'h0, 3'h0, mr | 14'h0100);
		cmd(4'h2, 3'h0, 14'h0400);
		cmd(4'h1, 3'h0, 14'h0000);
		cmd(4'h1, 3'h0, 14'h0000);
		cmd(4'h0, 3'h0, mr & 14'h3eff);
		tick(200);
		cmd(4'h0, 3'h1, e1 | 14'h0380);
		cmd(4'h0, 3'h1, e1 & 14'h3c7f);
	endtask
endmodule
`default_nettype wire

// >>> testbench/ddrmr_top_tb.sv
// Purpose: Self-checking bench of the DDR2 mode register block
// Assumes: Controller model issues the power-up sequence
// Notes: DLL lock count shortened to 4 memory clocks
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ddrmr_top_tb;
	import ddrmr_pkg::*;
	localparam logic [13:0] MR = 14'h0a63;
	localparam logic [13:0] E1 = 14'h0442;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0, wb_rdat;
	logic wb_ack, ck, clk_active, dll_ready;
	ddrmr_pins_t pins;
	ddrmr_mode_t mode;
	int miscompares = 0, n_checks = 0;
	always #10 clk_sys = ~clk_sys;
	ddrmr_top #(.DLL_CLKS(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ddr_ck_i(ck),
		.ddr_pins_i(pins), .mode_o(mode), .clk_active_o(clk_active),
		.dll_ready_o(dll_ready));
	ddrmr_ctl_model ctl_u (.ck(ck), .pins(pins));
	function automatic ddrmr_mode_t xm(logic [13:0] m, logic [13:0] e);
		return '{burst_len:m[2:0], burst_seq:m[3], cas_lat:m[6:4],
			test_mode:m[7], dll_reset:m[8], write_rec:m[11:9],
			dll_disable:e[0], odc_op:e[9:7]};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_sys);
		end while (wb_ack !== 1'b1);
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		`CHK(nm, e, r)
	endtask
	task automatic t_reset();
		logic [31:0] r;
		rd(8'h00, 32'h1, "ctrl");
		rd(8'h04, 32'h0, "status");
		wb(1'b1, 8'h08, 32'h1fff, r);
		rd(8'h08, 32'h0, "mmr ro");
		rd(8'h18, 32'h0, "unmapped");
	endtask
	task automatic t_init();
		ctl_u.init(MR, E1);
		rd(8'h08, {18'h0, MR}, "mmr");
		rd(8'h0c, {18'h0, E1}, "ext1");
		rd(8'h10, 32'h80, "ext2");
		rd(8'h14, 32'h0, "ext3");
		rd(8'h04, 32'hb, "status");
		`CHK("mode", xm(MR, E1), mode)
	endtask
	task automatic t_refuse();
		logic [31:0] r;
		ctl_u.cmd(4'h8, 3'h0, 14'h1234);
		ctl_u.cmd(4'h0, 3'h4, 14'h1234);
		wb(1'b1, 8'h00, 32'h0, r);
		ctl_u.cmd(4'h0, 3'h0, 14'h1234);
		wb(1'b1, 8'h00, 32'h1, r);
		ctl_u.cke_set(1'b0);
		ctl_u.cmd(4'h0, 3'h1, 14'h1234);
		`CHK("ck off", 1'b0, clk_active)
		ctl_u.cke_set(1'b1);
		rd(8'h08, {18'h0, MR}, "mmr kept");
		rd(8'h0c, {18'h0, E1}, "ext1 kept");
	endtask
	task automatic t_rewrite();
		ctl_u.cmd(4'h0, 3'h0, 14'h0632);
		ctl_u.cmd(4'h0, 3'h1, 14'h0001);
		`CHK("mode2", xm(14'h0632, 14'h0001), mode)
		`CHK("dll off", 1'b0, dll_ready)
		rd(8'h04, 32'h1, "status2");
		ctl_u.cmd(4'h0, 3'h1, 14'h0000);
		ctl_u.cmd(4'h0, 3'h0, 14'h0100);
		rd(8'h04, 32'hd, "dll locking");
		ctl_u.tick(4);
		rd(8'h04, 32'hb, "dll relocked");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_init();
		t_refuse();
		t_rewrite();
		finish_test();
	end
	initial begin
		#1000000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
